/* File: core/xmc_pkg.sv */
// Overview of operation
// [R1] Enable bit 7 of control A turns on the interface and claims its pins.
// [R2] While enabled, interface pin control overrides port direction settings.
// [R3] Clearing enable returns the pins to normal port function and direction.
// [R4] Limit field bits 6:4 splits external space into lower and upper sectors.
// [R5] Limit zero gives one sector using the upper wait-state bits.
// [R6] Codes 00x: upper 0x2200-0xFFFF; 010..111 move upper start 0x4000..0xE000.
// [R7] Upper-sector wait count comes from control A bits 3:2.
// [R8] Lower-sector wait count comes from control A bits 1:0.
// [R9] Wait codes: none, one, two strobe cycles, two plus one idle cycle.
// [R10] Keeper bit 7 of control B holds the last driven value on released lines.
// [R11] The keeper works whether or not the interface is enabled.
// [R12] Control B bits 6:3 read zero; software should write zeros there.
// [R13] High mask bits 2:0 release top high-address pins; 111 releases all.
// [R14] Each access compares its address with the selected sector boundary.
package xmc_pkg;
  localparam int         ADDR_W          = 7;
  localparam int         DATA_W          = 8;
  localparam logic [6:0] OFF_CTRL_A      = 7'h74;
  localparam logic [6:0] OFF_CTRL_B      = 7'h75;
  localparam logic [7:0] CTRL_A_RESET    = 8'h00;
  localparam logic [7:0] CTRL_B_RESET    = 8'h00;
  localparam int         BIT_ENABLE      = 7;
  localparam int         LIMIT_HI        = 6;
  localparam int         LIMIT_LO        = 4;
  localparam int         UPPER_WS_HI     = 3;
  localparam int         UPPER_WS_LO     = 2;
  localparam int         LOWER_WS_HI     = 1;
  localparam int         LOWER_WS_LO     = 0;
  localparam int         BIT_KEEPER      = 7;
  localparam int         MASK_HI         = 2;
  localparam int         MASK_LO         = 0;
  localparam logic [7:0] CTRL_B_RW_MASK  = 8'h87;
  localparam logic [15:0] EXT_BASE       = 16'h2200;
  localparam logic [15:0] SECTOR_STEP    = 16'h2000;
  localparam logic [2:0] LIMIT_FIRST     = 3'h2;
  localparam logic [2:0] LIMIT_LAST      = 3'h7;
  localparam logic [15:0] UPPER_FIRST    = 16'h4000;
  localparam logic [15:0] UPPER_LAST     = 16'he000;
  localparam logic [2:0] MASK_ALL_FREE   = 3'h7;
  localparam logic [1:0] WS_NONE         = 2'h0;
  localparam logic [1:0] WS_ONE          = 2'h1;
  localparam logic [1:0] WS_TWO          = 2'h2;
  localparam logic [1:0] WS_TWO_IDLE     = 2'h3;
  localparam logic [1:0] STRETCH_MAX     = 2'h2;

  typedef enum logic [1:0] {XMC_IDLE, XMC_STROBE, XMC_RECOVER} xmc_state_t;

  // Upper sector start: 0x2200 for codes 00x, else 0x4000 + (code-2)*0x2000.
  function automatic logic [15:0] xmc_upper_start(input logic [2:0] code);
    logic [15:0] steps;
    steps = {13'h0000, code - LIMIT_FIRST};
    if (code < LIMIT_FIRST) begin
      return EXT_BASE;
    end
    return UPPER_FIRST + 16'(steps * SECTOR_STEP);
  endfunction : xmc_upper_start
endpackage : xmc_pkg

/* File: core/xmc_regs.sv */
`timescale 1ns/1ns
module xmc_regs
  import xmc_pkg::*;
(
  input  wire logic                        clk,
  input  wire logic                        rstn,
  input  wire logic                        ce,
  input  wire logic [xmc_pkg::ADDR_W-1:0]  reg_addr,
  input  wire logic [xmc_pkg::DATA_W-1:0]  reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic      [xmc_pkg::DATA_W-1:0]  reg_rdata,
  output logic      [7:0]                  ctrl_a,
  output logic      [7:0]                  ctrl_b
);
  wire sel_a = (reg_addr == OFF_CTRL_A);
  wire sel_b = (reg_addr == OFF_CTRL_B);
  wire [7:0] rd_mux = sel_a ? ctrl_a : (sel_b ? ctrl_b : 8'h00);

  always_ff @(posedge clk) begin
    if (!rstn) begin
      ctrl_a    <= CTRL_A_RESET;
      ctrl_b    <= CTRL_B_RESET;
      reg_rdata <= 8'h00;
    end else if (ce) begin
      if (reg_wr && sel_a) begin
        ctrl_a <= reg_wdata;
      end
      // Reserved bits are never stored, so they read zero.
      if (reg_wr && sel_b) begin
        ctrl_b <= reg_wdata & CTRL_B_RW_MASK; // see [R12]
      end
      reg_rdata <= reg_rd ? rd_mux : 8'h00;
    end
  end

  property p_resv_zero;
    @(posedge clk) disable iff (!rstn) ctrl_b[6:3] == 4'h0;
  endproperty
  a_resv_zero: assert property (p_resv_zero) else $error("reserved bits nonzero"); // see [R12]
endmodule : xmc_regs

/* File: core/xmc_wait.sv */
`timescale 1ns/1ns
module xmc_wait
  import xmc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        ce,
  input  wire logic        start,
  input  wire logic [1:0]  ws_code,
  output logic             busy,
  output logic             strobe,
  output logic             done
);
  xmc_state_t state;
  logic [1:0] cnt;
  logic [1:0] code_q;
  wire  [1:0] stretch = (ws_code == WS_TWO_IDLE) ? STRETCH_MAX : ws_code;

  assign busy   = (state != XMC_IDLE);
  assign strobe = (state == XMC_STROBE);

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state  <= XMC_IDLE;
      cnt    <= 2'h0;
      code_q <= WS_NONE;
      done   <= 1'b0;
    end else if (ce) begin
      done <= 1'b0;
      unique case (state)
        XMC_IDLE: begin
          if (start) begin
            state  <= XMC_STROBE;
            cnt    <= stretch; // see [R9]
            code_q <= ws_code;
          end
        end
        XMC_STROBE: begin
          if (cnt != 2'h0) begin
            cnt <= cnt - 2'h1;
          end else if (code_q == WS_TWO_IDLE) begin
            state <= XMC_RECOVER; // see [R9]
          end else begin
            state <= XMC_IDLE;
            done  <= 1'b1;
          end
        end
        XMC_RECOVER: begin
          state <= XMC_IDLE;
          done  <= 1'b1;
        end
        default: state <= XMC_IDLE;
      endcase
    end
  end
endmodule : xmc_wait

/* File: core/xmc_top.sv */
`timescale 1ns/1ns
module xmc_top
  import xmc_pkg::*;
(
  input  wire logic                        clk,
  input  wire logic                        rstn,
  input  wire logic                        ce,
  input  wire logic [xmc_pkg::ADDR_W-1:0]  reg_addr,
  input  wire logic [xmc_pkg::DATA_W-1:0]  reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic      [xmc_pkg::DATA_W-1:0]  reg_rdata,
  input  wire logic                        acc_req,
  input  wire logic [15:0]                 acc_addr,
  output logic                             acc_busy,
  output logic                             acc_done,
  output logic                             acc_strobe,
  output logic                             acc_upper,
  output logic      [1:0]                  acc_wait_code,
  input  wire logic [7:0]                  port_ad_out,
  input  wire logic [7:0]                  port_ad_oe,
  input  wire logic [7:0]                  port_ha_out,
  input  wire logic [7:0]                  port_ha_oe,
  input  wire logic [7:0]                  if_ad_out,
  input  wire logic                        if_ad_drive,
  input  wire logic [7:0]                  mux_addr_data_lines_in,
  output logic      [7:0]                  mux_addr_data_lines_out,
  output logic      [7:0]                  mux_addr_data_lines_oe,
  output logic      [7:0]                  high_addr_lines_out,
  output logic      [7:0]                  high_addr_lines_oe,
  output logic                             ext_mem_enable,
  output logic                             bus_hold_enable,
  output logic      [7:0]                  high_addr_claimed
);
  logic [7:0] ctrl_a;
  logic [7:0] ctrl_b;
  logic [7:0] keep_val;
  logic       wait_busy;
  logic       wait_done;
  logic       wait_strobe;

  xmc_regs u_regs (
    .clk       (clk),
    .rstn      (rstn),
    .ce        (ce),
    .reg_addr  (reg_addr),
    .reg_wdata (reg_wdata),
    .reg_wr    (reg_wr),
    .reg_rd    (reg_rd),
    .reg_rdata (reg_rdata),
    .ctrl_a    (ctrl_a),
    .ctrl_b    (ctrl_b)
  );

  // ----------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------
  wire [2:0] sector_limit_sel = ctrl_a[LIMIT_HI:LIMIT_LO];
  wire [1:0] upper_wait_sel   = ctrl_a[UPPER_WS_HI:UPPER_WS_LO];
  wire [1:0] lower_wait_sel   = ctrl_a[LOWER_WS_HI:LOWER_WS_LO];
  wire [2:0] high_addr_mask   = ctrl_b[MASK_HI:MASK_LO];

  assign ext_mem_enable  = ctrl_a[BIT_ENABLE];  // see [R1]
  assign bus_hold_enable = ctrl_b[BIT_KEEPER];

  // ----------------------------------------------------------------
  // Sector selection
  // ----------------------------------------------------------------
  // Codes 00x give a boundary at the external base, so every external
  // address lands in the upper sector and uses its wait field.
  wire [15:0] upper_start = xmc_upper_start(sector_limit_sel); // see [R4] see [R6]
  wire        in_upper    = (acc_addr >= upper_start);          // see [R14] see [R5]
  wire [1:0]  sel_wait    = in_upper ? upper_wait_sel : lower_wait_sel; // see [R7] see [R8]
  wire        start_acc   = acc_req && ext_mem_enable && !wait_busy;

  assign acc_busy   = wait_busy;
  assign acc_done   = wait_done;
  assign acc_strobe = wait_strobe;

  xmc_wait u_wait (
    .clk     (clk),
    .rstn    (rstn),
    .ce      (ce),
    .start   (start_acc),
    .ws_code (sel_wait),
    .busy    (wait_busy),
    .strobe  (wait_strobe),
    .done    (wait_done)
  );

  always_ff @(posedge clk) begin
    if (!rstn) begin
      acc_upper     <= 1'b0;
      acc_wait_code <= WS_NONE;
    end else if (ce && start_acc) begin
      acc_upper     <= in_upper;
      acc_wait_code <= sel_wait;
    end
  end

  // ----------------------------------------------------------------
  // Pin ownership
  // ----------------------------------------------------------------
  // Mask code n leaves the low 8-n pins with the interface; code 7 frees all.
  wire [3:0] kept_pins  = 4'h8 - {1'b0, high_addr_mask};
  wire [7:0] kept_mask  = (high_addr_mask == MASK_ALL_FREE) ? 8'h00 : 8'((9'h001 << kept_pins) - 9'h001); // see [R13]
  assign high_addr_claimed = ext_mem_enable ? kept_mask : 8'h00;

  wire [7:0] ad_claim = {8{ext_mem_enable}};                   // see [R1]
  wire [7:0] ad_oe    = ext_mem_enable ? {8{if_ad_drive}} : port_ad_oe; // see [R2] see [R3]
  wire [7:0] ad_val   = ext_mem_enable ? if_ad_out : port_ad_out;

  // The keeper weakly re-drives the last sampled level; modelled as a drive
  // of the held value whenever nobody else drives the lines.
  wire [7:0] keep_oe  = bus_hold_enable ? ~ad_oe : 8'h00;      // see [R10] see [R11]
  assign mux_addr_data_lines_oe  = ad_oe | keep_oe;
  assign mux_addr_data_lines_out = (ad_oe & ad_val) | (keep_oe & keep_val);

  always_ff @(posedge clk) begin
    if (!rstn) begin
      keep_val <= 8'h00;
    end else if (ce) begin
      keep_val <= mux_addr_data_lines_in; // see [R10]
    end
  end

  assign high_addr_lines_out = (high_addr_claimed & acc_addr[15:8]) | (~high_addr_claimed & port_ha_out); // see [R13]
  assign high_addr_lines_oe  = high_addr_claimed | (~high_addr_claimed & port_ha_oe); // see [R2] see [R3]

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_ad_claim;
    @(posedge clk) disable iff (!rstn) (ext_mem_enable && !bus_hold_enable) |->
      (mux_addr_data_lines_oe == (ad_claim & {8{if_ad_drive}}));
  endproperty
  a_ad_claim: assert property (p_ad_claim) else $error("ad lines not claimed"); // see [R2]

  property p_release;
    @(posedge clk) disable iff (!rstn) (!ext_mem_enable && !bus_hold_enable) |-> (mux_addr_data_lines_oe == port_ad_oe);
  endproperty
  a_release: assert property (p_release) else $error("port direction not restored"); // see [R3]

  property p_enable_bit;
    @(posedge clk) disable iff (!rstn) (ce && reg_wr && reg_addr == OFF_CTRL_A) |=>
      (ext_mem_enable == $past(reg_wdata[BIT_ENABLE]));
  endproperty
  a_enable_bit: assert property (p_enable_bit) else $error("enable bit mismatch"); // see [R1]

  property p_single_sector;
    @(posedge clk) disable iff (!rstn) (sector_limit_sel[2:1] == 2'h0 && acc_addr >= EXT_BASE) |-> (sel_wait == upper_wait_sel);
  endproperty
  a_single_sector: assert property (p_single_sector) else $error("single sector not upper"); // see [R5]

  property p_lower;
    @(posedge clk) disable iff (!rstn) (sector_limit_sel == LIMIT_LAST && acc_addr < UPPER_LAST) |->
      (sel_wait == lower_wait_sel);
  endproperty
  a_lower: assert property (p_lower) else $error("lower sector wrong"); // see [R8]

  property p_upper;
    @(posedge clk) disable iff (!rstn) (sector_limit_sel == LIMIT_FIRST && acc_addr >= UPPER_FIRST) |->
      (sel_wait == upper_wait_sel);
  endproperty
  a_upper: assert property (p_upper) else $error("upper sector wrong"); // see [R7]

  property p_ws_none;
    @(posedge clk) disable iff (!rstn) (ce && start_acc && sel_wait == WS_NONE) ##1 ce |=> wait_done;
  endproperty
  a_ws_none: assert property (p_ws_none) else $error("zero wait length wrong"); // see [R9]

  property p_ws_idle;
    @(posedge clk) disable iff (!rstn) (start_acc && sel_wait == WS_TWO_IDLE && ce) ##1 (ce [*4]) |=> wait_done;
  endproperty
  a_ws_idle: assert property (p_ws_idle) else $error("idle cycle missing"); // see [R9]

  property p_ws_one;
    @(posedge clk) disable iff (!rstn) (start_acc && sel_wait == WS_ONE && ce) ##1 (ce [*2]) |=> wait_done;
  endproperty
  a_ws_one: assert property (p_ws_one) else $error("one wait length wrong"); // see [R9]

  property p_ws_two;
    @(posedge clk) disable iff (!rstn) (start_acc && sel_wait == WS_TWO && ce) ##1 (ce [*3]) |=> wait_done;
  endproperty
  a_ws_two: assert property (p_ws_two) else $error("two wait length wrong"); // see [R9]

  // A done that lasted two cycles would let the core count one access twice.
  property p_done_pulse;
    @(posedge clk) disable iff (!rstn) (wait_done && ce) |=> !wait_done;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done longer than one cycle"); // see [R9]

  property p_refuse;
    @(posedge clk) disable iff (!rstn) (!ext_mem_enable && !wait_busy) |=> !wait_busy;
  endproperty
  a_refuse: assert property (p_refuse) else $error("access started while disabled"); // see [R3]

  property p_high_drive;
    @(posedge clk) disable iff (!rstn) ext_mem_enable |->
      ((high_addr_lines_out & high_addr_claimed) == (acc_addr[15:8] & high_addr_claimed));
  endproperty
  a_high_drive: assert property (p_high_drive) else $error("high address not driven"); // see [R13]

  property p_high_free;
    @(posedge clk) disable iff (!rstn) !ext_mem_enable |->
      (high_addr_lines_oe == port_ha_oe && high_addr_lines_out == port_ha_out);
  endproperty
  a_high_free: assert property (p_high_free) else $error("high port not restored"); // see [R3]

  property p_mask_none;
    @(posedge clk) disable iff (!rstn) (ext_mem_enable && high_addr_mask == 3'h0) |-> (high_addr_claimed == 8'hff);
  endproperty
  a_mask_none: assert property (p_mask_none) else $error("mask 0 drops pins"); // see [R13]

  // The held level must be the one the lines showed at the previous edge.
  property p_keep_value;
    @(posedge clk) disable iff (!rstn) ce ##1 (bus_hold_enable && ad_oe == 8'h00) |->
      (mux_addr_data_lines_out == $past(mux_addr_data_lines_in));
  endproperty
  a_keep_value: assert property (p_keep_value) else $error("keeper lost the level"); // see [R10]

  property p_mask_all;
    @(posedge clk) disable iff (!rstn) (high_addr_mask == 3'h7) |-> (high_addr_claimed == 8'h00);
  endproperty
  a_mask_all: assert property (p_mask_all) else $error("mask 7 still drives"); // see [R13]

  property p_keeper;
    @(posedge clk) disable iff (!rstn) (bus_hold_enable && !ext_mem_enable && port_ad_oe == 8'h00) |-> (mux_addr_data_lines_oe == 8'hff);
  endproperty
  a_keeper: assert property (p_keeper) else $error("keeper inactive"); // see [R11]

  c_upper: cover property (@(posedge clk) start_acc && in_upper);
  c_lower: cover property (@(posedge clk) start_acc && !in_upper);
  c_idle:  cover property (@(posedge clk) start_acc && sel_wait == WS_TWO_IDLE);
  c_keep:  cover property (@(posedge clk) bus_hold_enable && !ext_mem_enable && ad_oe == 8'h00);
endmodule : xmc_top

/* File: sim/xmc_sram_model.sv */
`timescale 1ns/1ns
// ----------------------------------------------------------------
// External memory: answers reads on the shared lines
// ----------------------------------------------------------------
module xmc_sram_model (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       strobe,
  input  wire logic [7:0] ad_oe,
  output logic            drive,
  output logic [7:0]      data
);
  // The memory only drives while the strobe is up and the controller has let go.
  // That way two drivers never fight on the shared lines.
  assign drive = strobe & ~(|ad_oe);
  always_ff @(posedge clk) begin
    if (!rstn) begin
      data <= 8'h96;
    end else begin
      data <= data + 8'h3b;
    end
  end
endmodule : xmc_sram_model

/* File: sim/test_ext_memory_if_config.sv */
`timescale 1ns/1ns
module test_ext_memory_if_config;
  import xmc_pkg::*;
  logic clk = 0, rstn = 0, ce = 1, reg_wr = 0, reg_rd = 0, acc_req = 0, if_ad_drive = 0;
  logic [6:0] reg_addr = 7'h00;
  logic [7:0] reg_wdata = 8'h00, port_ad_out = 8'h00, port_ad_oe = 8'h00, port_ha_out = 8'h00;
  logic [7:0] port_ha_oe = 8'h00, if_ad_out = 8'h00, line, last_line = 8'h00, rd;
  logic [15:0] acc_addr = 16'h0000;
  logic [7:0] reg_rdata, ad_out, ad_oe, ha_out, ha_oe, claimed, p_data;
  logic busy, done, strobe, upper, en, keep, p_drv;
  logic [1:0] wcode;
  int error_cnt = 0, samples_checked = 0;
  initial forever #10 clk = ~clk;
  xmc_top xmc_top_inst (.clk(clk), .rstn(rstn), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .acc_req(acc_req), .acc_addr(acc_addr),
    .acc_busy(busy), .acc_done(done), .acc_strobe(strobe), .acc_upper(upper), .acc_wait_code(wcode),
    .port_ad_out(port_ad_out), .port_ad_oe(port_ad_oe), .port_ha_out(port_ha_out), .port_ha_oe(port_ha_oe),
    .if_ad_out(if_ad_out), .if_ad_drive(if_ad_drive), .mux_addr_data_lines_in(line),
    .mux_addr_data_lines_out(ad_out), .mux_addr_data_lines_oe(ad_oe), .high_addr_lines_out(ha_out),
    .high_addr_lines_oe(ha_oe), .ext_mem_enable(en), .bus_hold_enable(keep), .high_addr_claimed(claimed));
  xmc_sram_model xmc_sram_model_inst (.clk(clk), .rstn(rstn), .strobe(strobe), .ad_oe(ad_oe),
    .drive(p_drv), .data(p_data));
  // ----------------------------------------------------------------
  // Line level: an undriven line shows the inverse of its last level
  // ----------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      line[i] = ad_oe[i] ? ad_out[i] : (p_drv ? p_data[i] : ~last_line[i]);
    end
  end
  always @(posedge clk) last_line <= line;
  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : results
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check
  task automatic reg_write(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : reg_write
  task automatic reg_read(input logic [6:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask : reg_read
  task automatic t_regs;
    reg_read(OFF_CTRL_A, rd); check(rd, 16'(CTRL_A_RESET), "ctrl a reset");
    reg_read(OFF_CTRL_B, rd); check(rd, 16'(CTRL_B_RESET), "ctrl b reset");
    reg_write(OFF_CTRL_A, 8'h5c);
    reg_write(OFF_CTRL_B, 8'h87);
    reg_write(7'h10, 8'hff);
    reg_read(OFF_CTRL_A, rd); check(rd, 16'h005c, "ctrl a rw");
    reg_read(OFF_CTRL_B, rd); check(rd, 16'h0087, "ctrl b rw");
    reg_write(OFF_CTRL_B, 8'h78);
    reg_read(OFF_CTRL_B, rd); check(rd, 16'h0000, "ctrl b reserved bits");
    reg_read(7'h10, rd); check(rd, 16'h0000, "unmapped read");
  endtask : t_regs
  task automatic t_pins;
    logic [7:0] m;
    @(posedge clk);
    port_ad_out <= 8'h11; port_ad_oe <= 8'h0f; port_ha_out <= 8'hc3; port_ha_oe <= 8'h5a; if_ad_out <= 8'h5a;
    if_ad_drive <= 1'b1; acc_addr <= 16'h9600;
    reg_write(OFF_CTRL_A, 8'h80);
    @(negedge clk);
    check(en, 16'h0001, "enable bit");
    check(ad_out, 16'h005a, "lines carry interface value");
    check(ad_oe, 16'h00ff, "interface overrides port direction");
    for (int k = 0; k < 8; k++) begin
      reg_write(OFF_CTRL_B, 8'(k));
      @(negedge clk);
      m = (k == 7) ? 8'h00 : 8'(8'hff >> k);
      check(claimed, 16'(m), "high pins kept");
      check(ha_oe, 16'(m | (port_ha_oe & ~m)), "high pin direction");
      check(ha_out, 16'((m & 8'h96) | (~m & port_ha_out)), "high pin value");
    end
    reg_write(OFF_CTRL_B, 8'h00);
    reg_write(OFF_CTRL_A, 8'h00);
    @(negedge clk);
    check(ad_out & ad_oe, 16'h0001, "port value back");
    check(ad_oe, 16'h000f, "port direction back");
    check(claimed, 16'h0000, "no high pins kept");
    check(ha_oe, 16'h005a, "high port direction back");
    check(ha_out, 16'h00c3, "high port value back");
    @(posedge clk);
    if_ad_drive <= 1'b0; port_ad_oe <= 8'h00;
  endtask : t_pins
  task automatic access(input logic [15:0] a, input logic up, input logic [1:0] ws);
    int n;
    int s;
    @(posedge clk);
    acc_req <= 1'b1; acc_addr <= a;
    @(posedge clk);
    acc_req <= 1'b0;
    n = 0;
    s = 0;
    while (n < 12) begin
      @(negedge clk);
      n++;
      if (n == 1) begin
        check(busy, 16'h0001, "busy after start");
      end
      if (strobe === 1'b1) s++;
      if (done === 1'b1) break;
    end
    if (done !== 1'b1) begin
      check(done, 16'h0001, "access never finished");
      results();
    end else begin
      check(16'(n), 16'(2 + ws), "access length");
      check(16'(s), (ws == WS_TWO_IDLE) ? 16'(1 + WS_TWO) : 16'(1 + ws), "strobe length");
      check(busy, 16'h0000, "idle after done");
      check(upper, 16'(up), "sector choice");
      check(wcode, 16'(ws), "wait code used");
    end
  endtask : access
  task automatic t_sectors;
    logic [15:0] st;
    logic [1:0] wu;
    logic [1:0] wl;
    for (int lim = 0; lim < 8; lim++) begin
      st = (lim < 2) ? EXT_BASE : 16'h4000 + 16'(16'(lim - 2) * 16'h2000);
      wu = 2'(lim);
      wl = ~wu;
      reg_write(OFF_CTRL_A, 8'h80 | {1'b0, 3'(lim), wu, wl});
      access(st, 1'b1, wu);
      if (lim < 2) begin
        access(16'hffff, 1'b1, wu);
      end else begin
        access(st - 16'h0001, 1'b0, wl);
        access(EXT_BASE, 1'b0, wl);
      end
    end
  endtask : t_sectors
  task automatic t_refuse;
    reg_write(OFF_CTRL_A, 8'h0f);
    @(posedge clk);
    acc_req <= 1'b1; acc_addr <= 16'h8000;
    @(posedge clk);
    acc_req <= 1'b0;
    repeat (6) begin
      @(negedge clk);
      check(busy | done, 16'h0000, "access while disabled");
    end
  endtask : t_refuse
  task automatic t_keeper(input logic [7:0] ctrl_a, input logic [7:0] v);
    reg_write(OFF_CTRL_A, ctrl_a);
    reg_write(OFF_CTRL_B, 8'h80);
    port_ad_out <= v; port_ad_oe <= 8'hff; if_ad_out <= v; if_ad_drive <= 1'b1;
    @(posedge clk);
    port_ad_oe <= 8'h00; if_ad_drive <= 1'b0;
    check(keep, 16'h0001, "keeper bit");
    repeat (3) begin
      @(negedge clk);
      check(line, 16'(v), "held line level");
    end
    reg_write(OFF_CTRL_B, 8'h00);
  endtask : t_keeper
  // A write while the clock enable is low must be lost; a second reset mid-run must clear the registers.
  task automatic t_ce_reset;
    reg_write(OFF_CTRL_A, 8'h9f);
    @(posedge clk);
    ce <= 1'b0;
    reg_write(OFF_CTRL_A, 8'h00);
    @(posedge clk);
    ce <= 1'b1;
    reg_read(OFF_CTRL_A, rd); check(rd, 16'h009f, "frozen write ignored");
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
    check(en, 16'h0000, "enable after reset");
    reg_read(OFF_CTRL_A, rd); check(rd, 16'(CTRL_A_RESET), "ctrl a after reset");
  endtask : t_ce_reset
  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    t_regs();
    t_pins();
    t_sectors();
    t_refuse();
    t_keeper(8'h80, 8'ha5);
    t_keeper(8'h00, 8'h3c);
    t_ce_reset();
    results();
  end
endmodule : test_ext_memory_if_config
